// ---- core/pcm_clock_module.v ----
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pcm_defines.vh"
module pcm_clock_module (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // reset causes (levels from reset logic)
  input wire extResetReq,
  input wire wdResetReq,
  // oscillator ticks (async pins, synchronised here)
  input wire osc1Tick,
  input wire osc2Tick,
  input wire xtalTick,
  input wire gpio19In,
  input wire gpio38In,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // clock control outputs
  output reg sysClkEn,
  output reg wdClkEn,
  output reg timerClkEn,
  output reg pllPowerUp,
  output reg pllMultActive,
  output reg [3:0] pllMult,
  output reg osc1PowerUp,
  output reg osc2PowerUp,
  output reg xtalDriveEn,
  output reg lockAchieved
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [4:0] syncA_r;
  reg [4:0] syncB_r;
  reg [4:0] prev_r;
  reg [1:0] rstSyncA_r;
  reg [1:0] rstSyncB_r;
  always @(posedge sys_clk) begin
    syncA_r <= {gpio38In, gpio19In, xtalTick, osc2Tick, osc1Tick};
    syncB_r <= syncA_r;
    prev_r <= syncB_r;
    rstSyncA_r <= {wdResetReq, extResetReq};
    rstSyncB_r <= rstSyncA_r;
  end
  wire [4:0] rise = syncB_r & ~prev_r;
  // pin reset, watchdog reset or resetn; resetn alone is a power-up clear
  wire cfgReset = !resetn || (|rstSyncB_r);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [3:0] pll_ratio_control_r;
  reg [1:0] cpu_clock_in_divider_select_r;
  reg pll_power_down_bit_r;
  reg [8:0] clock_source_control_r;
  reg external_input_pin_select_r;
  reg [15:0] lockPeriod_r;
  reg [15:0] lastReset_r;
  wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wbWr = wbReq && wb_we_i;
  wire loLane = wb_sel_i[0];
  wire hiLane = wb_sel_i[1];
  wire ratioWr = wbWr && loLane && (wb_adr_i == `PCM_ADR_RATIO);
  wire lockNow;
  always @(posedge sys_clk) begin
    if (cfgReset) begin
      pll_ratio_control_r <= `PCM_RATIO_BYPASS;
      cpu_clock_in_divider_select_r <= `PCM_DIV_DEF;
      pll_power_down_bit_r <= 1'b0;
      lockPeriod_r <= `PCM_LOCK_DEF;
    end else if (wbWr) begin
      case (wb_adr_i)
        `PCM_ADR_RATIO: if (loLane) begin
          // ratios above twelve are not defined; keep the old one
          if (wb_dat_i[3:0] <= `PCM_RATIO_MAX)
            pll_ratio_control_r <= wb_dat_i[3:0];
        end
        `PCM_ADR_STATE: begin
          if (loLane)
            pll_power_down_bit_r <= wb_dat_i[`PCM_ST_OFF];
          if (loLane)
            cpu_clock_in_divider_select_r[0] <= wb_dat_i[`PCM_ST_DIV_LO];
          if (hiLane)
            cpu_clock_in_divider_select_r[1] <= wb_dat_i[`PCM_ST_DIV_HI];
        end
        `PCM_ADR_LOCKPRD: begin
          if (loLane) lockPeriod_r[7:0] <= wb_dat_i[7:0];
          if (hiLane) lockPeriod_r[15:8] <= wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end
  end
  // source selection is cleared only by power-up clear
  always @(posedge sys_clk) begin
    if (!resetn) begin
      clock_source_control_r <= `PCM_SRC_DEF;
      external_input_pin_select_r <= 1'b0;
    end else if (wbWr) begin
      if (wb_adr_i == `PCM_ADR_SRC) begin
        if (loLane) clock_source_control_r[7:0] <= wb_dat_i[7:0];
        if (hiLane)
          clock_source_control_r[8] <= wb_dat_i[`PCM_SRC_USEXTAL];
      end
      if (wb_adr_i == `PCM_ADR_CLKOUT && loLane)
        external_input_pin_select_r <= wb_dat_i[`PCM_CLKOUT_PINSEL];
    end
  end
  // debugger and missing-clock resets: recorded, config untouched
  always @(posedge sys_clk) begin
    if (!resetn) lastReset_r <= 16'h0000;
    else if (wbWr && loLane && hiLane && wb_adr_i == `PCM_ADR_RESET &&
             (wb_dat_i[15:0] == `PCM_DBG_KEY ||
              wb_dat_i[15:0] == `PCM_MCLK_KEY))
      lastReset_r <= wb_dat_i[15:0];
  end
  // ------------------------------------------------------------
  // oscillator clock selection
  // ------------------------------------------------------------
  wire useOsc2 = clock_source_control_r[`PCM_SRC_OSC2];
  wire extGate = clock_source_control_r[`PCM_SRC_EXTOFF];
  wire useXtal = clock_source_control_r[`PCM_SRC_USEXTAL];
  wire extPinTick = external_input_pin_select_r ? rise[4] : rise[3];
  wire extTick = extPinTick & ~extGate;
  wire xtalOn = !clock_source_control_r[`PCM_SRC_XTALOFF];
  // crystal used when external input is gated off or unused
  wire extSrcTick = (useXtal || extGate) ?
                    (rise[2] & xtalOn) : extTick;
  wire osc1Sel = rise[0] & ~clock_source_control_r[`PCM_SRC_OSC1OFF];
  wire osc2Sel = rise[1] & ~clock_source_control_r[`PCM_SRC_OSC2OFF];
  wire intTick = useOsc2 ? osc2Sel : osc1Sel;
  wire extMode = clock_source_control_r[`PCM_SRC_EXTSEL];
  wire oscTick = extMode ? extSrcTick : intTick;
  wire wdTick = clock_source_control_r[`PCM_SRC_WDOSC2] ?
                osc2Sel : osc1Sel;
  wire tmrTick = clock_source_control_r[`PCM_SRC_TMROSC2] ?
                 osc2Sel : osc1Sel;
  // ------------------------------------------------------------
  // pll model and lock
  // ------------------------------------------------------------
  // vco modelled as ratio pulses per reference tick
  reg [3:0] vcoLeft_r;
  reg vcoTick_r;
  wire pllOn = !pll_power_down_bit_r;
  wire ratioNz = pll_ratio_control_r != `PCM_RATIO_BYPASS;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      vcoLeft_r <= 4'h0;
      vcoTick_r <= 1'b0;
    end else if (oscTick && pllOn && ratioNz) begin
      vcoLeft_r <= pll_ratio_control_r - 4'h1;
      vcoTick_r <= 1'b1;
    end else if (vcoLeft_r != 4'h0) begin
      vcoLeft_r <= vcoLeft_r - 4'h1;
      vcoTick_r <= 1'b1;
    end else begin
      vcoTick_r <= 1'b0;
    end
  end
  pcm_lock_timer u_lock (
    .sys_clk(sys_clk),
    .resetn(!cfgReset),
    .restart(ratioWr),
    .tick(oscTick),
    .period(lockPeriod_r),
    .locked(lockNow)
  );
  // multiplied path only when enabled, nonzero and locked
  wire multUse = pllOn && ratioNz && lockNow;
  wire srcTick = multUse ? vcoTick_r : oscTick;
  // ------------------------------------------------------------
  // cpu clock divider
  // ------------------------------------------------------------
  reg [3:0] divRatio;
  always @* begin
    case (cpu_clock_in_divider_select_r)
      `PCM_DIV_BY2: divRatio = 4'h2;
      `PCM_DIV_BY1: divRatio = 4'h1;
      default: divRatio = 4'h4;
    endcase
  end
  wire cpuPulse;
  pcm_clk_div u_div (
    .sys_clk(sys_clk),
    .resetn(!cfgReset),
    .tick(srcTick),
    .ratio(divRatio),
    .pulse(cpuPulse)
  );
  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!resetn) begin
      sysClkEn <= 1'b0;
      wdClkEn <= 1'b0;
      timerClkEn <= 1'b0;
      pllPowerUp <= 1'b1;
      pllMultActive <= 1'b0;
      pllMult <= `PCM_RATIO_BYPASS;
      osc1PowerUp <= 1'b1;
      osc2PowerUp <= 1'b1;
      xtalDriveEn <= 1'b0;
      lockAchieved <= 1'b0;
    end else begin
      sysClkEn <= cpuPulse;
      wdClkEn <= wdTick;
      timerClkEn <= tmrTick;
      pllPowerUp <= pllOn;
      pllMultActive <= multUse;
      pllMult <= pll_ratio_control_r;
      osc1PowerUp <= !clock_source_control_r[`PCM_SRC_OSC1OFF];
      osc2PowerUp <= !clock_source_control_r[`PCM_SRC_OSC2OFF];
      xtalDriveEn <= xtalOn && extMode && (useXtal || extGate);
      lockAchieved <= lockNow;
    end
  end
  // ------------------------------------------------------------
  // wishbone read and ack
  // ------------------------------------------------------------
  reg [31:0] rdData;
  always @* begin
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      `PCM_ADR_RATIO: rdData[3:0] = pll_ratio_control_r;
      `PCM_ADR_STATE: begin
        rdData[`PCM_ST_LOCK] = lockNow;
        rdData[`PCM_ST_OFF] = pll_power_down_bit_r;
        rdData[`PCM_ST_DIV_HI:`PCM_ST_DIV_LO] = cpu_clock_in_divider_select_r;
      end
      `PCM_ADR_SRC: rdData[8:0] = clock_source_control_r;
      `PCM_ADR_CLKOUT:
        rdData[`PCM_CLKOUT_PINSEL] = external_input_pin_select_r;
      `PCM_ADR_LOCKPRD: rdData[15:0] = lockPeriod_r;
      `PCM_ADR_RESET: rdData[15:0] = lastReset_r;
      default: rdData = 32'h0000_0000;
    endcase
  end
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) wb_dat_o <= rdData;
    end
  end
endmodule // pcm_clock_module

// ---- core/pcm_defines.vh ----
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH
// ------------------------------------------------------------
// register byte offsets (wishbone, one word each)
// ------------------------------------------------------------
`define PCM_ADR_CLKOUT 8'h10
`define PCM_ADR_STATE 8'h14
`define PCM_ADR_SRC 8'h18
`define PCM_ADR_RATIO 8'h1C
`define PCM_ADR_LOCKPRD 8'h20
`define PCM_ADR_RESET 8'h24
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PCM_ST_LOCK 0
`define PCM_ST_OFF 1
`define PCM_ST_DIV_LO 7
`define PCM_ST_DIV_HI 8
`define PCM_SRC_OSC2 0
`define PCM_SRC_OSC1OFF 1
`define PCM_SRC_OSC2OFF 2
`define PCM_SRC_XTALOFF 3
`define PCM_SRC_EXTOFF 4
`define PCM_SRC_WDOSC2 5
`define PCM_SRC_TMROSC2 6
`define PCM_SRC_EXTSEL 7
`define PCM_SRC_USEXTAL 8
`define PCM_CLKOUT_PINSEL 6
// ------------------------------------------------------------
// reset values and encodings
// ------------------------------------------------------------
`define PCM_RATIO_BYPASS 4'h0
`define PCM_RATIO_MAX 4'hC
`define PCM_DIV_DEF 2'h0
`define PCM_DIV_BY2 2'h2
`define PCM_DIV_BY1 2'h3
`define PCM_LOCK_DEF 16'h0FFF
`define PCM_SRC_DEF 9'h000
`define PCM_DBG_KEY 16'h00D6
`define PCM_MCLK_KEY 16'h00A5
`endif

// ---- core/pcm_lock_timer.v ----
`timescale 1ns/1ps
// lock counter: counts reference ticks after a ratio write
module pcm_lock_timer (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // control
  input wire restart,
  input wire tick,
  input wire [15:0] period,
  // status
  output reg locked
);
  reg [15:0] count_r;
  // no lock until a ratio write arms the count; flag stays low after reset
  reg armed_r;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      count_r <= 16'h0000;
      armed_r <= 1'b0;
      locked <= 1'b0;
    end else if (restart) begin
      count_r <= period;
      armed_r <= 1'b1;
      locked <= 1'b0;
    end else if (tick && armed_r && !locked) begin
      if (count_r == 16'h0000) locked <= 1'b1;
      else count_r <= count_r - 16'h0001;
    end
  end
endmodule // pcm_lock_timer

// ---- core/pcm_clk_div.v ----
`timescale 1ns/1ps
// enable divider: pulse once every 'ratio' tick inputs
module pcm_clk_div (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // control
  input wire tick,
  input wire [3:0] ratio,
  // output enable pulse
  output reg pulse
);
  reg [3:0] cnt_r;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (cnt_r + 4'h1 >= ratio) begin
          cnt_r <= 4'h0;
          pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule // pcm_clk_div

// ---- testbench/pcm_clock_props.sv ----
`timescale 1ns/1ps
`include "pcm_defines.vh"
// ------------------------------------------------------------
// port checks for the clock module
// ------------------------------------------------------------
module pcm_clock_props (
  // clock and reset
  input logic sys_clk,
  input logic resetn,
  // causes
  input logic extResetReq,
  input logic wdResetReq,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  // effects
  input logic wb_ack_o,
  input logic pllPowerUp,
  input logic pllMultActive,
  input logic [3:0] pllMult,
  input logic lockAchieved
);
  default clocking cb @(posedge sys_clk); endclocking
  sequence sTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sRatioWr;
    sTaken ##0 (wb_we_i && wb_adr_i == `PCM_ADR_RATIO);
  endsequence
  // requests pass a two-stage synchroniser first
  sequence sPinReset;
    (extResetReq || wdResetReq) [*6];
  endsequence
  a_ack_after_req: assert property (disable iff (!resetn)
    sTaken |=> wb_ack_o) else $error("request not acknowledged");
  a_ack_one_cycle: assert property (disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_needs_req: assert property (disable iff (!resetn)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_mult_needs_lock: assert property (disable iff (!resetn)
    pllMultActive |-> lockAchieved) else $error("multiplied without lock");
  a_write_forces_bypass: assert property (disable iff (!resetn)
    sRatioWr |-> ##3 (!lockAchieved && !pllMultActive))
    else $error("no bypass after ratio write");
  a_zero_ratio_bypass: assert property (disable iff (!resetn)
    (pllMult == `PCM_RATIO_BYPASS) [*3] |-> !pllMultActive)
    else $error("multiplied with zero ratio");
  a_ratio_in_range: assert property (disable iff (!resetn)
    pllMult <= `PCM_RATIO_MAX) else $error("ratio above twelve");
  a_pin_reset_clears: assert property (disable iff (!resetn)
    sPinReset |-> (pllMult == 4'h0 && !lockAchieved && pllPowerUp))
    else $error("pin reset did not restore");
  a_reset_defaults: assert property (
    !resetn |=> (pllPowerUp && !pllMultActive && pllMult == 4'h0))
    else $error("wrong reset state");
endmodule // pcm_clock_props

bind pcm_clock_module pcm_clock_props i_props (.sys_clk, .resetn,
  .extResetReq, .wdResetReq, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_ack_o, .pllPowerUp, .pllMultActive, .pllMult, .lockAchieved);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "pcm_defines.vh"
module tb_top;
  logic sys_clk = 0, resetn = 0, extResetReq = 0, wdResetReq = 0;
  logic wbCyc = 0, wbStb = 0, wbWe = 0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0000_0000, q, wb_dat_o;
  logic [7:0] tickCnt = 8'h00;
  logic wb_ack_o, sysClkEn, wdClkEn, timerClkEn, pllPowerUp, pllMultActive;
  logic osc1PowerUp, osc2PowerUp, xtalDriveEn, lockAchieved;
  logic [3:0] pllMult;
  integer failures = 0, comparisons = 0, i, g;
  always #2.5 sys_clk = ~sys_clk;
  // slow reference ticks, well under a quarter of sys_clk
  always @(posedge sys_clk) tickCnt <= tickCnt + 8'h01;
  pcm_clock_module i_dut (.sys_clk, .resetn, .extResetReq, .wdResetReq,
    .osc1Tick(tickCnt[2]), .osc2Tick(tickCnt[3]), .xtalTick(tickCnt[2]),
    .gpio19In(tickCnt[3]), .gpio38In(tickCnt[4]), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDat), .wb_dat_o, .wb_ack_o, .sysClkEn, .wdClkEn,
    .timerClkEn, .pllPowerUp, .pllMultActive, .pllMult, .osc1PowerUp,
    .osc2PowerUp, .xtalDriveEn, .lockAchieved);
  task wrap_up;
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDat <= d;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    if (n >= 50) failures = failures + 1;
    q = wb_dat_o;
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    @(posedge sys_clk);
  endtask
  task waitLock;
    integer n;
    n = 0;
    while (lockAchieved !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    if (n >= 600) failures = failures + 1;
  endtask
  function logic pick(input integer w);
    case (w)
      0: pick = sysClkEn;
      1: pick = wdClkEn;
      default: pick = timerClkEn;
    endcase
  endfunction
  // cycles between two successive enable pulses
  task gapOf(input integer w, output integer gap);
    integer n;
    n = 0;
    @(posedge sys_clk);
    while (pick(w) !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    gap = 0;
    @(posedge sys_clk);
    while (pick(w) !== 1'b1 && gap < 200) begin
      @(posedge sys_clk);
      gap = gap + 1;
    end
    gap = gap + 1;
  endtask
  task tResetState;
    chk(pllPowerUp, 1);
    chk({osc1PowerUp, osc2PowerUp, pllMultActive}, 3'b110);
    xfer(0, `PCM_ADR_STATE, 0);
    chk(q & 32'h0000_0183, 0);
    xfer(0, `PCM_ADR_RATIO, 0);
    chk(q[3:0], 0);
    gapOf(0, g);
    chk(g, 32);
    gapOf(1, g);
    chk(g, 8);
  endtask
  task tLock;
    xfer(1, `PCM_ADR_LOCKPRD, 32'h0000_0004);
    xfer(1, `PCM_ADR_RATIO, 32'h0000_000C);
    chk({pllMult, lockAchieved, pllMultActive}, 6'h30);
    waitLock;
    chk({lockAchieved, pllMultActive}, 2'b11);
    xfer(0, `PCM_ADR_STATE, 0);
    chk(q[0], 1);
    xfer(1, `PCM_ADR_RATIO, 32'h0000_000D);
    xfer(0, `PCM_ADR_RATIO, 0);
    chk(q[3:0], 4'hC);
    xfer(1, `PCM_ADR_RATIO, 32'h0000_0005);
    chk({pllMult, pllMultActive}, 5'h0A);
    waitLock;
    chk(pllMultActive, 1);
  endtask
  task tResets;
    xfer(1, `PCM_ADR_RESET, `PCM_DBG_KEY);
    xfer(1, `PCM_ADR_RESET, `PCM_MCLK_KEY);
    xfer(0, `PCM_ADR_RATIO, 0);
    chk(q[3:0], 4'h5);
    for (i = 0; i < 2; i = i + 1) begin
      xfer(1, `PCM_ADR_RATIO, 32'h0000_0003);
      extResetReq <= (i == 0);
      wdResetReq <= (i == 1);
      repeat (6) @(posedge sys_clk);
      extResetReq <= 1'b0;
      wdResetReq <= 1'b0;
      repeat (4) @(posedge sys_clk);
      xfer(0, `PCM_ADR_RATIO, 0);
      chk({q[3:0], lockAchieved, pllMultActive}, 6'h00);
    end
  endtask
  task tPowerAndSources;
    xfer(1, `PCM_ADR_STATE, 32'h0000_0002);
    chk(pllPowerUp, 0);
    xfer(1, `PCM_ADR_STATE, 32'h0000_0180);
    xfer(0, `PCM_ADR_STATE, 0);
    chk(q & 32'h0000_0183, 32'h0000_0180);
    chk(pllPowerUp, 1);
    gapOf(0, g);
    chk(g, 8);
    xfer(1, `PCM_ADR_CLKOUT, 32'h0000_0040);
    xfer(0, `PCM_ADR_CLKOUT, 0);
    chk(q[6], 1);
    xfer(1, `PCM_ADR_SRC, 32'h0000_0180);
    chk(xtalDriveEn, 1);
    xfer(1, `PCM_ADR_SRC, 32'h0000_0040);
    gapOf(2, g);
    chk(g, 16);
    xfer(1, `PCM_ADR_SRC, 32'h0000_0012);
    xfer(0, `PCM_ADR_SRC, 0);
    chk({q[4], q[1], osc1PowerUp}, 3'b110);
    xfer(0, 8'h40, 0);
    chk(q, 0);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    tResetState;
    tLock;
    tResets;
    tPowerAndSources;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures = failures + 1;
    wrap_up;
  end
endmodule // tb_top
